// ===== brc_map.vh
// Purpose: constants of the serial command relay
// Assumes: 4 MHz master clock scaled to the 25 MHz system clock
// Notes: definitions only
`ifndef BRC_MAP_VH
`define BRC_MAP_VH
`define BRC_CLK_HZ 25000000
`define BRC_BAUD 4800
`define BRC_BIT_CYC (`BRC_CLK_HZ / `BRC_BAUD)
`define BRC_HALF_CYC (`BRC_BIT_CYC / 2)
`define BRC_CNT_W 13
`define BRC_MCLK_HZ 4000000
`define BRC_WORD_MCLK 81920
// Scaled by 1000 so the product stays inside 32-bit integer arithmetic
`define BRC_WORD_CYC ((`BRC_CLK_HZ / 1000) * `BRC_WORD_MCLK / (`BRC_MCLK_HZ / 1000))
`define BRC_WORD_W 20
`define BRC_RD_BASE 8'h50
`define BRC_WR_BASE 8'hd0
`define BRC_CMD_MASK 8'h07
`define BRC_IDX_CONV 3'h0
`define BRC_IDX_LAST 3'h6
`define BRC_CFG_RST 24'h000000
`define BRC_FIFO_DEPTH 8
`endif

// ===== brc_fifo.v
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes: full and empty derived from a count
`timescale 1ns/10ps
module brc_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire sys_clk,
   input wire rst,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] count_reg;
   wire push;
   wire pop;
   assign in_ready = (count_reg != DEPTH[AW:0]);
   assign out_valid = (count_reg != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end
   always @(posedge sys_clk) begin
      if (rst) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule // brc_fifo

// ===== brc_relay.v
// Purpose: serial command relay between a host UART and converter registers
// Assumes: host line idles high; conversion words and reference presence are inputs
// Notes: read answers are buffered in an 8-byte FIFO ahead of the transmitter
//
// How it works
// - The host line runs at 4800 baud, 8 data bits, no parity, one stop bit.
// - A write command is followed by exactly three bytes forming a 24-bit value.
// - Payload bytes come low byte first and each byte LSB first.
// - Codes 50h to 56h read conversion, config, gain, DAC and three offsets.
// - Codes D1h to D6h write those registers; the conversion word has no write code.
// - A new conversion word is taken at about 48.8 Hz, every 81,920 master clocks.
// - Without a reference the conversion result reads zero.
// - The new-word flag drops at each new word and rises once its third byte is handed to the FIFO.
`timescale 1ns/10ps
`include "brc_map.vh"
module brc_relay (
   input wire sys_clk,
   input wire rst,
   input wire host_rx,
   output reg host_tx,
   input wire [23:0] conv_in,
   input wire ref_present,
   output reg new_word_flag_n,
   output reg [23:0] cfg_out,
   output reg [23:0] gain_out,
   output reg [23:0] dac_out,
   output reg [23:0] ain_r_ofs_out,
   output reg [23:0] ain_n_ofs_out,
   output reg [23:0] ref_n_ofs_out,
   output reg cmd_error
);
   localparam S_CMD = 4'b0001;
   localparam S_DATA = 4'b0010;
   localparam S_RESP = 4'b0100;
   localparam S_IDLE = 4'b1000;
   localparam integer BIT_CYC_I = `BRC_BIT_CYC;
   localparam integer HALF_CYC_I = `BRC_HALF_CYC;
   localparam integer WORD_CYC_I = `BRC_WORD_CYC;
   localparam [`BRC_CNT_W-1:0] BIT_CYC = BIT_CYC_I[`BRC_CNT_W-1:0];
   localparam [`BRC_CNT_W-1:0] HALF_CYC = HALF_CYC_I[`BRC_CNT_W-1:0];
   localparam [`BRC_WORD_W-1:0] WORD_CYC = WORD_CYC_I[`BRC_WORD_W-1:0];

   // Receiver
   reg [`BRC_CNT_W-1:0] rx_cnt_reg;
   reg [3:0] rx_bit_reg;
   reg [7:0] rx_shift_reg;
   reg rx_busy_reg;
   reg rx_done_reg;
   always @(posedge sys_clk) begin
      if (rst) begin
         rx_cnt_reg <= {`BRC_CNT_W{1'b0}};
         rx_bit_reg <= 4'h0;
         rx_shift_reg <= 8'h00;
         rx_busy_reg <= 1'b0;
         rx_done_reg <= 1'b0;
      end else begin
         rx_done_reg <= 1'b0;
         if (!rx_busy_reg) begin
            if (!host_rx) begin
               rx_busy_reg <= 1'b1;
               rx_cnt_reg <= HALF_CYC;
               rx_bit_reg <= 4'h0;
            end
         end else if (rx_cnt_reg != {`BRC_CNT_W{1'b0}}) begin
            rx_cnt_reg <= rx_cnt_reg - 1'b1;
         end else begin
            rx_cnt_reg <= BIT_CYC - 1'b1;
            rx_bit_reg <= rx_bit_reg + 1'b1;
            if (rx_bit_reg == 4'h0) begin
               if (host_rx) begin
                  rx_busy_reg <= 1'b0; // False start glitch
               end
            end else if (rx_bit_reg < 4'h9) begin
               rx_shift_reg <= {host_rx, rx_shift_reg[7:1]};
            end else begin
               rx_busy_reg <= 1'b0;
               rx_done_reg <= host_rx;
            end
         end
      end
   end

   // Conversion word capture
   reg [`BRC_WORD_W-1:0] word_cnt_reg;
   reg [23:0] conv_reg;
   always @(posedge sys_clk) begin
      if (rst) begin
         word_cnt_reg <= {`BRC_WORD_W{1'b0}};
         conv_reg <= 24'h000000;
      end else if (word_cnt_reg == WORD_CYC - 1'b1) begin
         word_cnt_reg <= {`BRC_WORD_W{1'b0}};
         conv_reg <= ref_present ? conv_in : 24'h000000;
      end else begin
         word_cnt_reg <= word_cnt_reg + 1'b1;
      end
   end

   // Command decode
   reg [3:0] state_reg;
   reg [2:0] idx_reg;
   reg [1:0] byte_cnt_reg;
   reg [23:0] data_reg;
   reg [23:0] rd_val;
   reg fifo_valid_reg;
   reg [7:0] fifo_byte_reg;
   wire fifo_in_ready;
   wire [2:0] code_idx;
   wire code_ok;
   assign code_idx = rx_shift_reg[2:0];
   assign code_ok = ((rx_shift_reg & ~`BRC_CMD_MASK) == `BRC_RD_BASE
      || (rx_shift_reg & ~`BRC_CMD_MASK) == `BRC_WR_BASE)
      && code_idx <= `BRC_IDX_LAST;
   always @* begin
      case (idx_reg)
         3'h0: rd_val = conv_reg;
         3'h1: rd_val = cfg_out;
         3'h2: rd_val = gain_out;
         3'h3: rd_val = dac_out;
         3'h4: rd_val = ain_r_ofs_out;
         3'h5: rd_val = ain_n_ofs_out;
         3'h6: rd_val = ref_n_ofs_out;
         default: rd_val = 24'h000000;
      endcase
   end
   always @(posedge sys_clk) begin
      if (rst) begin
         state_reg <= S_CMD;
         idx_reg <= 3'h0;
         byte_cnt_reg <= 2'h0;
         data_reg <= 24'h000000;
         fifo_valid_reg <= 1'b0;
         fifo_byte_reg <= 8'h00;
         cmd_error <= 1'b0;
         cfg_out <= `BRC_CFG_RST;
         gain_out <= 24'h000000;
         dac_out <= 24'h000000;
         ain_r_ofs_out <= 24'h000000;
         ain_n_ofs_out <= 24'h000000;
         ref_n_ofs_out <= 24'h000000;
      end else begin
         if (fifo_valid_reg && fifo_in_ready) begin
            fifo_valid_reg <= 1'b0;
         end
         case (state_reg)
            S_CMD: begin
               if (rx_done_reg) begin
                  idx_reg <= code_idx;
                  byte_cnt_reg <= 2'h0;
                  cmd_error <= !code_ok
                     || (rx_shift_reg[7] && code_idx == `BRC_IDX_CONV);
                  if (code_ok && !rx_shift_reg[7]) begin
                     state_reg <= S_RESP;
                  end else if (code_ok && code_idx != `BRC_IDX_CONV) begin
                     state_reg <= S_DATA;
                  end
               end
            end
            S_DATA: begin
               if (rx_done_reg) begin
                  data_reg <= {rx_shift_reg, data_reg[23:8]};
                  byte_cnt_reg <= byte_cnt_reg + 1'b1;
                  if (byte_cnt_reg == 2'h2) begin
                     state_reg <= S_IDLE;
                  end
               end
            end
            S_IDLE: begin
               state_reg <= S_CMD;
               case (idx_reg)
                  3'h1: cfg_out <= data_reg;
                  3'h2: gain_out <= data_reg;
                  3'h3: dac_out <= data_reg;
                  3'h4: ain_r_ofs_out <= data_reg;
                  3'h5: ain_n_ofs_out <= data_reg;
                  3'h6: ref_n_ofs_out <= data_reg;
                  default: cmd_error <= 1'b1;
               endcase
            end
            S_RESP: begin
               // Waits on the FIFO so answer bytes are never dropped
               if (!fifo_valid_reg || fifo_in_ready) begin
                  fifo_valid_reg <= 1'b1;
                  fifo_byte_reg <= rd_val[8*byte_cnt_reg +: 8];
                  byte_cnt_reg <= byte_cnt_reg + 1'b1;
                  if (byte_cnt_reg == 2'h2) begin
                     state_reg <= S_CMD;
                  end
               end
            end
            default: state_reg <= S_CMD;
         endcase
      end
   end

   wire [7:0] tx_data;
   wire tx_valid;
   reg tx_take_reg;
   brc_fifo #(
      .WIDTH(8),
      .DEPTH(`BRC_FIFO_DEPTH),
      .AW(3)
   ) u_fifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .in_data(fifo_byte_reg),
      .in_valid(fifo_valid_reg),
      .in_ready(fifo_in_ready),
      .out_data(tx_data),
      .out_valid(tx_valid),
      .out_ready(tx_take_reg)
   );

   // Transmitter: start, 8 data LSB first, stop
   reg [`BRC_CNT_W-1:0] tx_cnt_reg;
   reg [3:0] tx_bit_reg;
   reg [8:0] tx_shift_reg;
   reg tx_busy_reg;
   always @(posedge sys_clk) begin
      if (rst) begin
         tx_cnt_reg <= {`BRC_CNT_W{1'b0}};
         tx_bit_reg <= 4'h0;
         tx_shift_reg <= 9'h1ff;
         tx_busy_reg <= 1'b0;
         tx_take_reg <= 1'b0;
         host_tx <= 1'b1;
      end else begin
         tx_take_reg <= 1'b0;
         if (!tx_busy_reg) begin
            host_tx <= 1'b1;
            if (tx_valid && !tx_take_reg) begin
               tx_take_reg <= 1'b1;
               tx_busy_reg <= 1'b1;
               tx_shift_reg <= {1'b1, tx_data};
               tx_bit_reg <= 4'h0;
               tx_cnt_reg <= BIT_CYC - 1'b1;
               host_tx <= 1'b0;
            end
         end else if (tx_cnt_reg != {`BRC_CNT_W{1'b0}}) begin
            tx_cnt_reg <= tx_cnt_reg - 1'b1;
         end else if (tx_bit_reg == 4'h9) begin
            tx_busy_reg <= 1'b0;
         end else begin
            tx_cnt_reg <= BIT_CYC - 1'b1;
            tx_bit_reg <= tx_bit_reg + 1'b1;
            host_tx <= tx_shift_reg[0];
            tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
         end
      end
   end

   // New-word flag: low on a fresh word, high once its third read byte is loaded into the FIFO input register
   always @(posedge sys_clk) begin
      if (rst) begin
         new_word_flag_n <= 1'b1;
      end else if (word_cnt_reg == WORD_CYC - 1'b1) begin
         new_word_flag_n <= 1'b0;
      end else if (state_reg == S_RESP && idx_reg == `BRC_IDX_CONV
         && byte_cnt_reg == 2'h2 && (!fifo_valid_reg || fifo_in_ready)) begin
         new_word_flag_n <= 1'b1;
      end
   end
endmodule // brc_relay

// ===== brc_host_model.sv
// Purpose: host serial port model facing the relay
// Assumes: 8N1 framing at the relay bit period
// Notes: bytes heard on host_tx queue in rx_q; n_bad counts bad stop bits
`timescale 1ns/10ps
`include "brc_map.vh"
module brc_host_model (
   input wire sys_clk,
   input wire host_tx,
   output logic host_rx
);
   localparam int BT = `BRC_BIT_CYC;
   logic [7:0] rx_q[$];
   logic [7:0] b;
   int n_bad = 0;
   initial host_rx = 1'b1;
   task automatic send(input logic [7:0] d);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         host_rx <= f[i];
         repeat (BT) @(negedge sys_clk);
      end
   endtask
   // Sample mid-bit so edge jitter of a cycle cannot flip a bit
   always begin
      @(negedge host_tx);
      repeat (BT / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BT) @(posedge sys_clk);
         b[i] = host_tx;
      end
      repeat (BT) @(posedge sys_clk);
      if (host_tx !== 1'b1) n_bad++;
      rx_q.push_back(b);
   end
endmodule // brc_host_model

// ===== brc_relay_asserts.sv
// Purpose: port checker for the serial command relay
// Assumes: one clock, synchronous reset
// Notes: run counters stand in for long repetitions
`timescale 1ns/10ps
`include "brc_map.vh"
module brc_relay_asserts (
   input wire sys_clk,
   input wire rst,
   input wire host_rx,
   input wire host_tx,
   input wire new_word_flag_n,
   input wire [23:0] cfg_out,
   input wire [23:0] gain_out,
   input wire [23:0] dac_out,
   input wire [23:0] ain_r_ofs_out,
   input wire [23:0] ain_n_ofs_out,
   input wire [23:0] ref_n_ofs_out,
   input wire cmd_error
);
   localparam int BT = `BRC_BIT_CYC;
   localparam int HB = `BRC_HALF_CYC - 8;
   localparam int WC = `BRC_WORD_CYC;
   int rx_hi = 0;
   int tx_lo = 0;
   int tx_hi = 0;
   int since_fall = 0;
   logic seen = 1'b0;
   wire [143:0] regs = {cfg_out, gain_out, dac_out, ain_r_ofs_out, ain_n_ofs_out, ref_n_ofs_out};
   always @(posedge sys_clk) begin
      rx_hi <= host_rx ? rx_hi + 1 : 0;
      tx_lo <= host_tx ? 0 : tx_lo + 1;
      tx_hi <= host_tx ? tx_hi + 1 : 0;
      since_fall <= $fell(new_word_flag_n) ? 1 : since_fall + 1;
      seen <= rst ? 1'b0 : (seen | $fell(new_word_flag_n));
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Actions land only once a stop bit has been sampled
   sequence stop_seen;
      rx_hi >= HB;
   endsequence
   chk_reset_state: assert property (disable iff (1'b0) rst |=> host_tx && new_word_flag_n
      && !cmd_error && regs == 144'h0) else $error("bad state after reset");
   chk_reg_update: assert property (!$stable(regs) |-> stop_seen)
      else $error("register changed before stop bit");
   chk_one_reg: assert property ($onehot0({!$stable(cfg_out), !$stable(gain_out),
      !$stable(dac_out), !$stable(ain_r_ofs_out), !$stable(ain_n_ofs_out),
      !$stable(ref_n_ofs_out)})) else $error("several registers written at once");
   chk_bad_code: assert property ($rose(cmd_error) |-> stop_seen and $stable(regs))
      else $error("error flag without clean refusal");
   chk_tx_bit_len: assert property ($rose(host_tx) |-> tx_lo % BT == 0)
      else $error("low run not whole bit periods");
   chk_tx_stop_len: assert property ($fell(host_tx) |-> tx_hi >= BT)
      else $error("start bit without full stop bit");
   chk_word_rate: assert property ($fell(new_word_flag_n) |-> !seen || since_fall % WC == 0)
      else $error("new word flag off word period");
   chk_flag_rise: assert property ($rose(new_word_flag_n) |-> stop_seen)
      else $error("new word flag rose without a command");
endmodule // brc_relay_asserts
bind brc_relay brc_relay_asserts brc_relay_asserts_i (.*);

// ===== brc_relay_test.sv
// Purpose: self-checking bench of the serial command relay
// Assumes: bit and word periods fixed by constants, so the run is long
// Notes: writes every register, reads each back, then the conversion word
`timescale 1ns/10ps
`include "brc_map.vh"
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin n_mismatch++; \
   $display("ERROR %s exp %h got %h", n, e, s); end end
module brc_relay_test;
   localparam int BT = `BRC_BIT_CYC;
   localparam int WC = `BRC_WORD_CYC;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic ref_present = 1'b1;
   logic [23:0] conv_in = 24'h0;
   logic [31:0] seed = 32'h2da9;
   logic [23:0] v [1:6];
   logic [23:0] got;
   wire host_rx, host_tx, new_word_flag_n, cmd_error;
   wire [23:0] regs [1:6];
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;
   always #20 sys_clk = ~sys_clk;
   brc_relay brc_relay_i (.sys_clk(sys_clk), .rst(rst), .host_rx(host_rx), .host_tx(host_tx),
      .conv_in(conv_in), .ref_present(ref_present), .new_word_flag_n(new_word_flag_n),
      .cfg_out(regs[1]), .gain_out(regs[2]), .dac_out(regs[3]), .ain_r_ofs_out(regs[4]),
      .ain_n_ofs_out(regs[5]), .ref_n_ofs_out(regs[6]), .cmd_error(cmd_error));
   brc_host_model brc_host_model_i (.sys_clk(sys_clk), .host_tx(host_tx), .host_rx(host_rx));
   task end_sim;
      if (n_mismatch == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 4000000) begin
         n_mismatch++;
         end_sim();
      end
   end
   task automatic rnd(output logic [23:0] r);
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      r = seed[23:0];
   endtask
   task automatic wr(input logic [7:0] c, input logic [23:0] d);
      brc_host_model_i.send(c);
      for (int i = 0; i < 3; i++) brc_host_model_i.send(d[8*i +: 8]);
   endtask
   // The answer is awaited with a bound so a silent relay cannot hang the run
   task automatic rd(input logic [7:0] c, output logic [23:0] d);
      int t;
      d = 24'hx;
      brc_host_model_i.send(c);
      t = 0;
      while (brc_host_model_i.rx_q.size() < 3 && t < 40 * BT) begin
         @(negedge sys_clk);
         t++;
      end
      if (brc_host_model_i.rx_q.size() >= 3)
         for (int i = 0; i < 3; i++) d[8*i +: 8] = brc_host_model_i.rx_q.pop_front();
   endtask
   // Ticks land on cycle counts equal to the reset length modulo the word period
   task automatic wait_word(input logic hi_before);
      @(negedge sys_clk);
      while (cyc % WC != 9) @(negedge sys_clk);
      `CHK("flag before tick", hi_before, new_word_flag_n)
      @(negedge sys_clk);
      `CHK("flag at tick", 1'b0, new_word_flag_n)
   endtask
   initial begin
      repeat (10) @(negedge sys_clk);
      rst = 1'b0;
      @(negedge sys_clk);
      `CHK("host_tx idle", 1'b1, host_tx)
      `CHK("flag idle", 1'b1, new_word_flag_n)
      rnd(got);
      conv_in = got;
      brc_host_model_i.send(8'h57);
      `CHK("err 57", 1'b1, cmd_error)
      for (int k = 1; k <= 6; k++) begin
         rnd(v[k]);
         wr(8'hd0 + 8'(k), v[k]);
         `CHK("reg write", v[k], regs[k])
         `CHK("err clear", 1'b0, cmd_error)
      end
      // Sent while the error flag is clear, so a missed refusal shows
      brc_host_model_i.send(8'hd0);
      `CHK("err d0", 1'b1, cmd_error)
      for (int k = 1; k <= 6; k++) begin
         rd(8'h50 + 8'(k), got);
         `CHK("reg read", v[k], got)
         `CHK("err read clear", 1'b0, cmd_error)
      end
      brc_host_model_i.send(8'h13);
      `CHK("err base", 1'b1, cmd_error)
      `CHK("regs kept", v[1], regs[1])
      // No conversion read yet, so the flag is still low from the first tick
      wait_word(1'b0);
      rd(8'h50, got);
      `CHK("conv read", conv_in, got)
      `CHK("flag high", 1'b1, new_word_flag_n)
      ref_present = 1'b0;
      wait_word(1'b1);
      rd(8'h50, got);
      `CHK("no reference", 24'h0, got)
      `CHK("stop bits", 0, brc_host_model_i.n_bad)
      end_sim();
   end
endmodule // brc_relay_test
